// file: hw/cpr_cfg.svh
// constants for the copper line control register bank
// assumes inclusion by bare name from the package only
`ifndef CPR_CFG_SVH
`define CPR_CFG_SVH
`define CPR_ADDR_W 5
`define CPR_OFF_EXT_STATUS 5'h0F
`define CPR_OFF_LINE_CTRL 5'h10
`define CPR_OFF_BASIC_CTRL 5'h00
`define CPR_OFF_KEEPALIVE 5'h1A
`define CPR_EXT_STATUS_VAL 16'h3000
`define CPR_BIT_LP_DIS 15
`define CPR_DS_CNT_HI 14
`define CPR_DS_CNT_LO 12
`define CPR_BIT_DS_EN 11
`define CPR_BIT_FORCE_LINK 10
`define CPR_EDET_HI 9
`define CPR_EDET_LO 8
`define CPR_BIT_EXT_DIST 7
`define CPR_XOVER_HI 6
`define CPR_XOVER_LO 5
`define CPR_BIT_RSVD4 4
`define CPR_BIT_TX_DIS 3
`define CPR_BIT_PWR_DOWN 2
`define CPR_BIT_POL_DIS 1
`define CPR_BIT_JAB_DIS 0
`define CPR_BIT_SW_RESET 15
`define CPR_BIT_ANEG_RESTART 9
`define CPR_BIT_BASIC_PD 11
`define CPR_BIT_KEEPALIVE 3
`define CPR_DS_CNT_RST 3'h3
`define CPR_XOVER_RST 2'h3
`endif

// file: hw/cpr_pkg.sv
// types for the copper line control register bank
// assumes cpr_cfg.svh is on the include path
package cpr_pkg;
  `include "cpr_cfg.svh"
  typedef enum logic [1:0] {
    CPR_XO_MDI,
    CPR_XO_MDIX,
    CPR_XO_RSVD,
    CPR_XO_AUTO
  } cpr_xover_t;
  // settings that only change on a software reset or on the strap load after reset
  typedef struct packed {
    logic [2:0] ds_count;
    logic ds_enable;
    logic [1:0] edet;
    cpr_xover_t xover;
  } cpr_deferred_t;
  // controls driven to the copper datapath
  typedef struct packed {
    logic link_pulse_en;
    logic [3:0] ds_attempts;
    logic ds_enable;
    logic force_link_good;
    logic edet_on;
    logic edet_send_nlp;
    logic low_rx_threshold;
    cpr_xover_t xover;
    logic tx_enable;
    logic powered_down;
    logic gmii_on;
    logic auto_polarity;
    logic jabber_en;
  } cpr_ctrl_t;
endpackage : cpr_pkg

// file: hw/cpr_regs.sv
// copper line control and extended capability status registers
// assumes a synchronous plain register port and a synchronous strap input
//
// Behaviour
// - extended status 1000BASE-X bits read zero
// - extended status 1000BASE-T bits read one
// - extended status low twelve bits zero, read-only
// - link-pulse disable bit stops link pulses
// - downshift code N gives N+1 attempts
// - deferred fields apply only on software reset or the strap load after reset
// - downshift enable allows speed fallback
// - force link good except in gigabit
// - energy detect off, sense, or sense+pulses
// - energy detect resets from strap input
// - extended distance lowers 10BASE-T threshold
// - crossover mode MDI, MDIX, reserved, auto
// - transmitter disable keeps value through soft reset
// - powered down while either power-down bit set
// - power-up exit forces software reset, renegotiation
// - keepalive bit keeps GMII during power down
// - polarity disable forces normal 10BASE-T polarity
// - jabber disable only matters in 10BASE-T half
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module cpr_regs
  import cpr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`CPR_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [1:0] energy_detect_strap_input,
  input wire logic gigabit_mode,
  output logic soft_reset_pulse,
  output logic aneg_restart_pulse,
  output var cpr_ctrl_t ctrl
);

  logic [15:0] line_q, line_d;
  cpr_deferred_t act_q, act_d;
  logic basic_pd_q, basic_pd_d;
  logic keep_q, keep_d;
  logic pd_q, pd_d;
  logic strap_load_q, strap_load_d;
  logic [15:0] rdata_q, rdata_d;
  logic srst_q, srst_d;
  logic aneg_q, aneg_d;
  cpr_ctrl_t ctrl_q, ctrl_d;
  logic wr_line, wr_basic, pd_now, pd_exit, soft_rst;

  always_comb begin
    wr_line = reg_wr && (reg_addr == `CPR_OFF_LINE_CTRL);
    wr_basic = reg_wr && (reg_addr == `CPR_OFF_BASIC_CTRL);
    line_d = line_q;
    basic_pd_d = basic_pd_q;
    keep_d = keep_q;
    strap_load_d = 1'b0;
    if (strap_load_q) begin
      line_d[`CPR_EDET_HI:`CPR_EDET_LO] = energy_detect_strap_input;
    end
    if (wr_line) begin
      line_d = reg_wdata;
    end
    if (wr_basic) begin
      basic_pd_d = reg_wdata[`CPR_BIT_BASIC_PD];
    end
    if (reg_wr && (reg_addr == `CPR_OFF_KEEPALIVE)) begin
      keep_d = reg_wdata[`CPR_BIT_KEEPALIVE];
    end
    pd_now = basic_pd_d | line_d[`CPR_BIT_PWR_DOWN];
    pd_d = pd_now;
    pd_exit = pd_q && !pd_now;
    soft_rst = (wr_basic && reg_wdata[`CPR_BIT_SW_RESET]) || pd_exit;
    srst_d = soft_rst;
    aneg_d = pd_exit || (wr_basic && reg_wdata[`CPR_BIT_ANEG_RESTART]);
    if (soft_rst) begin
      line_d[`CPR_BIT_LP_DIS] = 1'b0;
    end
    act_d = act_q;
    if (soft_rst || strap_load_q) begin
      act_d.ds_count = line_d[`CPR_DS_CNT_HI:`CPR_DS_CNT_LO];
      act_d.ds_enable = line_d[`CPR_BIT_DS_EN];
      act_d.edet = line_d[`CPR_EDET_HI:`CPR_EDET_LO];
      act_d.xover = cpr_xover_t'(line_d[`CPR_XOVER_HI:`CPR_XOVER_LO]);
    end
    rdata_d = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == `CPR_OFF_EXT_STATUS) begin
        rdata_d = `CPR_EXT_STATUS_VAL;
      end else if (reg_addr == `CPR_OFF_LINE_CTRL) begin
        rdata_d = line_q;
      end else if (reg_addr == `CPR_OFF_BASIC_CTRL) begin
        rdata_d = {4'h0, basic_pd_q, 11'h000};
      end else if (reg_addr == `CPR_OFF_KEEPALIVE) begin
        rdata_d = {12'h000, keep_q, 3'h0};
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  always_comb begin
    ctrl_d.link_pulse_en = !line_q[`CPR_BIT_LP_DIS];
    ctrl_d.ds_attempts = {1'b0, act_q.ds_count} + 4'h1;
    ctrl_d.ds_enable = act_q.ds_enable;
    ctrl_d.force_link_good = line_q[`CPR_BIT_FORCE_LINK] && !gigabit_mode;
    ctrl_d.edet_on = act_q.edet[1];
    ctrl_d.edet_send_nlp = act_q.edet[1] && act_q.edet[0];
    ctrl_d.low_rx_threshold = line_q[`CPR_BIT_EXT_DIST];
    ctrl_d.xover = act_q.xover;
    ctrl_d.tx_enable = !line_q[`CPR_BIT_TX_DIS];
    ctrl_d.powered_down = pd_q;
    ctrl_d.gmii_on = !pd_q || keep_q;
    ctrl_d.auto_polarity = !line_q[`CPR_BIT_POL_DIS];
    ctrl_d.jabber_en = !line_q[`CPR_BIT_JAB_DIS];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      line_q <= {1'b0, `CPR_DS_CNT_RST, 1'b0, 1'b0, 2'h0, 1'b0,
                 `CPR_XOVER_RST, 5'h00};
      act_q <= '{ds_count: `CPR_DS_CNT_RST, ds_enable: 1'b0, edet: 2'h0,
                 xover: CPR_XO_AUTO};
      basic_pd_q <= 1'b0;
      keep_q <= 1'b0;
      pd_q <= 1'b0;
      strap_load_q <= 1'b1;
      rdata_q <= 16'h0000;
      srst_q <= 1'b0;
      aneg_q <= 1'b0;
      ctrl_q <= '0;
    end else begin
      line_q <= line_d;
      act_q <= act_d;
      basic_pd_q <= basic_pd_d;
      keep_q <= keep_d;
      pd_q <= pd_d;
      strap_load_q <= strap_load_d;
      rdata_q <= rdata_d;
      srst_q <= srst_d;
      aneg_q <= aneg_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign soft_reset_pulse = srst_q;
  assign aneg_restart_pulse = aneg_q;
  assign ctrl = ctrl_q;

endmodule : cpr_regs
`default_nettype wire

// file: verification/cpr_strap_model.sv
// board-side strap model
// assumes the strap is static
`timescale 1ns/1ns
`default_nettype none
module cpr_strap_model (
  output wire logic [1:0] energy_detect_strap_input
);
  assign energy_detect_strap_input = 2'h2;
endmodule : cpr_strap_model
`default_nettype wire

// file: verification/cpr_regs_checker.sv
// port assertions for the register bank
// assumes binding to cpr_regs
`timescale 1ns/1ns
`default_nettype none
module cpr_regs_checker
  import cpr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic gigabit_mode,
  input wire logic soft_reset_pulse,
  input wire cpr_ctrl_t ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence w10;
    reg_wr && reg_addr == 5'h10 ##1 !soft_reset_pulse [*2];
  endsequence
  a_ext_read: assert property (reg_rd && reg_addr == 5'h0F |=> reg_rdata == 16'h3000)
    else $error("ext status");
  a_lp_write: assert property (w10 |-> ctrl.link_pulse_en == !$past(reg_wdata[15], 2))
    else $error("link pulse");
  a_kept_fields: assert property (w10 |-> ctrl.low_rx_threshold == $past(reg_wdata[7], 2)
    && ctrl.tx_enable == !$past(reg_wdata[3], 2) && ctrl.auto_polarity == !$past(reg_wdata[1], 2)
    && ctrl.jabber_en == !$past(reg_wdata[0], 2)) else $error("kept fields");
  a_deferred_hold: assert property (w10 |-> $stable(ctrl.ds_attempts) && $stable(ctrl.xover))
    else $error("deferred");
  a_ds_range: assert property (resetn [*4] |-> ctrl.ds_attempts != 4'h0)
    else $error("attempts");
  a_pd_write: assert property (w10 |-> !$past(reg_wdata[2], 2) || ctrl.powered_down)
    else $error("power down");
  a_force_gig: assert property (gigabit_mode && $past(gigabit_mode) |-> !ctrl.force_link_good)
    else $error("force link");
  a_swrst_req: assert property (reg_wr && reg_addr == 5'h00 && reg_wdata[15] |=> soft_reset_pulse)
    else $error("soft reset");
  cover property (w10);
  cover property (soft_reset_pulse);
  cover property (ctrl.powered_down);
endmodule : cpr_regs_checker
bind cpr_regs cpr_regs_checker chk_i (.*);
`default_nettype wire

// file: verification/tb_cpr_regs.sv
// register bank bench
// assumes design, strap model and checker compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_cpr_regs;
  import cpr_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, gigabit_mode = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [1:0] energy_detect_strap_input;
  logic soft_reset_pulse, aneg_restart_pulse;
  cpr_ctrl_t ctrl;
  int mismatches = 0, checked = 0, cyc = 0, ns = 0, na = 0;
  cpr_strap_model lm (.*);
  cpr_regs uut (.*);
  initial forever #20 clk = ~clk;
  task automatic end_sim;
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
    @(posedge clk);
  endtask : rd
  always @(posedge clk) begin
    cyc++;
    if (soft_reset_pulse === 1'b1) ns++;
    if (aneg_restart_pulse === 1'b1) na++;
    if (cyc > 3000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(5'h10, 16'h3260);
    rd(5'h0F, 16'h3000);
    wr(5'h0F, 16'hFFFF);
    rd(5'h0F, 16'h3000);
    rd(5'h05, 16'h0000);
    chk("dfr", 16'({ctrl.ds_attempts, ctrl.ds_enable, ctrl.xover}), 16'h0023);
    chk("edet", 16'({ctrl.edet_on, ctrl.edet_send_nlp}), 16'h0002);
    wr(5'h10, 16'hFF8B);
    rd(5'h10, 16'hFF8B);
    chk("lptx", 16'({ctrl.link_pulse_en, ctrl.tx_enable}), 16'h0000);
    chk("rxpj", 16'({ctrl.low_rx_threshold, ctrl.auto_polarity, ctrl.jabber_en}), 16'h0004);
    chk("frc", 16'(ctrl.force_link_good), 16'h0001);
    chk("dfr", 16'({ctrl.ds_attempts, ctrl.ds_enable, ctrl.xover}), 16'h0023);
    wr(5'h00, 16'h8000);
    chk("dfr", 16'({ctrl.ds_attempts, ctrl.ds_enable, ctrl.xover}), 16'h0044);
    chk("edet", 16'({ctrl.edet_on, ctrl.edet_send_nlp}), 16'h0003);
    rd(5'h10, 16'h7F8B);
    chk("lptx", 16'({ctrl.link_pulse_en, ctrl.tx_enable}), 16'h0002);
    gigabit_mode <= 1'b1;
    repeat (3) @(posedge clk);
    chk("frc", 16'(ctrl.force_link_good), 16'h0000);
    wr(5'h1A, 16'h0008);
    wr(5'h10, 16'h7F8F);
    chk("pdg", 16'({ctrl.powered_down, ctrl.gmii_on}), 16'h0003);
    wr(5'h1A, 16'h0000);
    chk("pdg", 16'({ctrl.powered_down, ctrl.gmii_on}), 16'h0002);
    wr(5'h00, 16'h0800);
    wr(5'h10, 16'h7F8B);
    chk("pd", 16'(ctrl.powered_down), 16'h0001);
    wr(5'h00, 16'h0000);
    chk("pd", 16'(ctrl.powered_down), 16'h0000);
    chk("nsr", 16'(ns), 16'h0002);
    chk("nan", 16'(na), 16'h0001);
    end_sim();
  end
endmodule : tb_cpr_regs
`default_nettype wire
